// [logic/le_uart_buf_defs.svh]
// Offsets, bit positions and reset values of the serial buffer and flag block.
// Assumes byte addressing on a 32-bit register bus, one word per register.
`ifndef LE_UART_BUF_DEFS_SVH
`define LE_UART_BUF_DEFS_SVH
// Register offsets
`define OFF_CMD         8'h04
`define OFF_STATUS      8'h08
`define OFF_RX_EXT_POP  8'h18
`define OFF_RX_BYTE     8'h1C
`define OFF_RX_PEEK     8'h20
`define OFF_TX_EXT      8'h24
`define OFF_TX_BYTE     8'h28
`define OFF_FLAGS       8'h2C
`define OFF_FLAG_SET    8'h30
`define OFF_FLAG_CLR    8'h34
`define OFF_ENABLES     8'h38
// Frame view fields
`define BIT_FRAMING_ERROR        15
`define BIT_PARITY_ERROR        14
`define BIT_RX_ON_AFTER 15
`define BIT_TX_OFF_AFTER 14
`define BIT_BREAK       13
// Event flag positions
`define FL_TX_DONE      0
`define FL_TX_ROOM      1
`define FL_RX_VALID     2
`define FL_RX_OVF       3
`define FL_RX_UNF       4
`define FL_TX_OVF       5
`define FL_PARITY_ERROR         6
`define FL_FRAMING_ERROR         7
`define FL_MPA          8
`define FL_START        9
`define FL_SIG          10
`define FLAG_W          11
`define FLAG_SW_MASK    11'h7F9
`define FLAG_RESET      11'h002
// Command bits
`define CMD_RX_ON       0
`define CMD_RX_OFF      1
`define CMD_TX_ON       2
`define CMD_TX_OFF      3
`define CMD_BLOCK_ON    4
`define CMD_BLOCK_OFF   5
`endif

// [logic/le_uart_buf_pkg.sv]
// Types shared by the serial buffer and flag block.
// Assumes the defs header is compiled alongside.
package le_uart_buf_pkg;
  // One received frame with its error marks
  typedef struct packed {
    logic       framing_error;
    logic       parity_error;
    logic [8:0] data;
  } rx_frame_t;
  // One frame to transmit with its per-frame controls
  typedef struct packed {
    logic       rx_on;
    logic       tx_off;
    logic       brk;
    logic [8:0] data;
  } tx_frame_t;
  // Kinds of frame the receive engine recognises
  typedef struct packed {
    logic sig;
    logic start;
    logic mpa;
  } rx_detect_t;
  // Bus slave phases
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_st_t;
endpackage

// [logic/le_uart_buf.sv]
// Buffers and event flags of a low-energy serial port, Avalon-MM slave.
// Assumes an external framing engine that hands over received frames
// as pulses and takes transmit frames with a valid/ready handshake.
`include "le_uart_buf_defs.svh"

// Overview of operation
// - Extended view returns frame, errors, pops
// - Peek view shows same frame without pop
// - Transmit-off control disables transmitter after frame
// - Break control replaces stop bits with zeros
// - Byte transmit view clears ninth bit, controls
// - Write to full buffer flags, discards
// - Read from empty buffer flags underflow
// - New frame over full shifter flags, overwrites
// - Frame reaching receive buffer sets valid flag
// - Room flag set on room, resets set
// - Done flag when buffer and shifter empty
// - Error flags only while blocking is off
// - Signal, start, address frames set flags
// - Only enabled flags request an interrupt
module le_uart_buf
  import le_uart_buf_pkg::*;
(
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  // Avalon-MM slave
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Receive engine side
  input  wire logic        RX_FRAME_VALID,
  input  wire rx_frame_t   RX_FRAME,
  input  wire rx_detect_t  RX_DETECT,
  output logic             RX_ENABLE,
  // Transmit engine side
  output logic             TX_VALID,
  output tx_frame_t        TX_FRAME,
  input  wire logic        TX_READY,
  input  wire logic        TX_SENT,
  output logic             TX_ENABLE,
  // Interrupt request
  output logic             IRQ
);

  // Extended receive view, shared by pop and peek reads
  function automatic logic [31:0] ext_view(input rx_frame_t f);
    ext_view = {16'h0000, f.framing_error, f.parity_error, 5'h00, f.data};
  endfunction

  bus_st_t              st_q;
  logic                 wait_q;
  logic [31:0]          rdata_q;
  logic [`FLAG_W-1:0]   flags_q;
  logic [`FLAG_W-1:0]   en_q;
  logic                 irq_q;
  logic                 rx_on_q;
  logic                 tx_on_q;
  logic                 block_q;
  rx_frame_t            sh_q;
  logic                 sh_v_q;
  rx_frame_t            rxb_q;
  logic                 rxb_v_q;
  tx_frame_t            d0_q;
  tx_frame_t            d1_q;
  logic                 v0_q;
  logic                 v1_q;
  tx_frame_t            fl_q;
  logic                 busy_q;
  logic                 done_q;

  logic [7:0]           addr;
  logic                 acc;
  logic                 rd;
  logic                 wr;
  logic                 rd_pop;
  logic                 rx_pop;
  logic                 rx_acc;
  logic                 move;
  logic                 tx_wr;
  logic                 tx_push;
  logic                 tx_pop;
  tx_frame_t            tx_new;
  logic [`FLAG_W-1:0]   hw_set;
  logic [`FLAG_W-1:0]   hw_clr;
  logic [`FLAG_W-1:0]   sw_set;
  logic [`FLAG_W-1:0]   sw_clr;
  logic [`FLAG_W-1:0]   flags_d;

  // Request decode; an access happens once, on the idle edge
  assign addr   = {AVS_ADDRESS[7:2], 2'b00};
  assign acc    = (st_q == BUS_IDLE) && (AVS_READ || AVS_WRITE);
  assign rd     = acc && AVS_READ;
  assign wr     = acc && AVS_WRITE && !AVS_READ;
  assign rd_pop = rd && (addr == `OFF_RX_BYTE || addr == `OFF_RX_EXT_POP);
  assign rx_pop = rd_pop && rxb_v_q;

  // Bus handshake: waitrequest drops for exactly one cycle
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_q   <= BUS_IDLE;
      wait_q <= 1'b1;
    end else begin
      case (st_q)
        BUS_IDLE: begin
          if (acc) begin
            st_q   <= BUS_ACK;
            wait_q <= 1'b0;
          end
        end
        BUS_ACK: begin
          st_q   <= BUS_IDLE;
          wait_q <= 1'b1;
        end
        default: begin
          st_q   <= BUS_IDLE;
          wait_q <= 1'b1;
        end
      endcase
    end
  end

  // Read data, captured on the access edge; unmapped reads give zero
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd) begin
      case (addr)
        `OFF_STATUS:     rdata_q <= {26'h000_0000, rxb_v_q, !v1_q, done_q, block_q, tx_on_q, rx_on_q};
        `OFF_RX_EXT_POP: rdata_q <= ext_view(rxb_q);
        `OFF_RX_PEEK:    rdata_q <= ext_view(rxb_q);
        `OFF_RX_BYTE:    rdata_q <= {24'h00_0000, rxb_q.data[7:0]};
        `OFF_FLAGS:      rdata_q <= {21'h00_0000, flags_q};
        `OFF_ENABLES:    rdata_q <= {21'h00_0000, en_q};
        default:         rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Interrupt enables, one per flag at the same position
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      en_q <= 11'h000;
    end else if (wr && addr == `OFF_ENABLES) begin
      en_q <= AVS_WRITEDATA[`FLAG_W-1:0];
    end
  end

  // Receiver, transmitter and blocking controls
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rx_on_q <= 1'b0;
      tx_on_q <= 1'b0;
      block_q <= 1'b0;
    end else begin
      if (wr && addr == `OFF_CMD) begin
        if (AVS_WRITEDATA[`CMD_RX_ON])     rx_on_q <= 1'b1;
        if (AVS_WRITEDATA[`CMD_RX_OFF])    rx_on_q <= 1'b0;
        if (AVS_WRITEDATA[`CMD_TX_ON])     tx_on_q <= 1'b1;
        if (AVS_WRITEDATA[`CMD_TX_OFF])    tx_on_q <= 1'b0;
        if (AVS_WRITEDATA[`CMD_BLOCK_ON])  block_q <= 1'b1;
        if (AVS_WRITEDATA[`CMD_BLOCK_OFF]) block_q <= 1'b0;
      end
      // Per-frame controls act when the engine reports the frame sent
      if (TX_SENT && busy_q && fl_q.rx_on)  rx_on_q <= 1'b1;
      if (TX_SENT && busy_q && fl_q.tx_off) tx_on_q <= 1'b0;
    end
  end

  // Receive path: shifter feeds a one-word buffer
  assign rx_acc = RX_FRAME_VALID && rx_on_q && !block_q;
  assign move   = sh_v_q && (!rxb_v_q || rx_pop);

  // Shift register stage; a new frame overwrites an unmoved one
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sh_v_q <= 1'b0;
      sh_q   <= '0;
    end else if (rx_acc) begin
      sh_v_q <= 1'b1;
      sh_q   <= RX_FRAME;
    end else if (move) begin
      sh_v_q <= 1'b0;
    end
  end

  // Receive buffer stage; reads pop it, peeks leave it
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rxb_v_q <= 1'b0;
      rxb_q   <= '0;
    end else if (move) begin
      rxb_v_q <= 1'b1;
      rxb_q   <= sh_q;
    end else if (rx_pop) begin
      rxb_v_q <= 1'b0;
    end
  end

  // Transmit write decode; the byte view drops bit 8 and all controls
  assign tx_wr   = wr && (addr == `OFF_TX_EXT || addr == `OFF_TX_BYTE);
  assign tx_push = tx_wr && !v1_q;
  assign tx_pop  = v0_q && TX_READY;
  always_comb begin
    tx_new = '0;
    if (addr == `OFF_TX_EXT) begin
      tx_new.data   = AVS_WRITEDATA[8:0];
      tx_new.rx_on  = AVS_WRITEDATA[`BIT_RX_ON_AFTER];
      tx_new.tx_off = AVS_WRITEDATA[`BIT_TX_OFF_AFTER];
      tx_new.brk    = AVS_WRITEDATA[`BIT_BREAK];
    end else begin
      tx_new.data   = {1'b0, AVS_WRITEDATA[7:0]};
    end
  end

  // Two-entry transmit buffer; head slot drives the engine directly
  // so a stalled engine fills the buffer, and writes to a full buffer are discarded
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      v0_q <= 1'b0;
      v1_q <= 1'b0;
      d0_q <= '0;
      d1_q <= '0;
    end else begin
      case ({tx_pop, tx_push})
        2'b11: begin
          d0_q <= v1_q ? d1_q : tx_new;
          d1_q <= tx_new;
          v1_q <= v1_q;
        end
        2'b10: begin
          d0_q <= d1_q;
          v0_q <= v1_q;
          v1_q <= 1'b0;
        end
        2'b01: begin
          if (!v0_q) begin
            d0_q <= tx_new;
            v0_q <= 1'b1;
          end else begin
            d1_q <= tx_new;
            v1_q <= 1'b1;
          end
        end
        default: begin
          v0_q <= v0_q;
        end
      endcase
    end
  end

  // Frame in the engine's shifter, and the completion level
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      busy_q <= 1'b0;
      fl_q   <= '0;
      done_q <= 1'b0;
    end else begin
      if (tx_pop) begin
        busy_q <= 1'b1;
        fl_q   <= d0_q;
        done_q <= 1'b0;
      end else if (TX_SENT) begin
        busy_q <= 1'b0;
        if (!v0_q) done_q <= 1'b1;
      end
    end
  end

  // Hardware events per flag bit
  always_comb begin
    hw_set = '0;
    hw_set[`FL_TX_DONE]  = TX_SENT && busy_q && !v0_q && !tx_pop;
    hw_set[`FL_TX_ROOM]  = v1_q && tx_pop;
    hw_set[`FL_RX_VALID] = move;
    hw_set[`FL_RX_OVF]   = rx_acc && sh_v_q && !move;
    hw_set[`FL_RX_UNF]   = rd_pop && !rxb_v_q;
    hw_set[`FL_TX_OVF]   = tx_wr && v1_q;
    hw_set[`FL_PARITY_ERROR]     = rx_acc && RX_FRAME.parity_error;
    hw_set[`FL_FRAMING_ERROR]     = rx_acc && RX_FRAME.framing_error;
    hw_set[`FL_MPA]      = rx_on_q && RX_DETECT.mpa;
    hw_set[`FL_START]    = rx_on_q && RX_DETECT.start;
    hw_set[`FL_SIG]      = rx_on_q && RX_DETECT.sig;
    // Level-style flags follow their buffers when software cannot clear them
    hw_clr = '0;
    hw_clr[`FL_TX_ROOM]  = v1_q;
    hw_clr[`FL_RX_VALID] = !rxb_v_q;
  end

  // Software set and clear masks; bits 2:1 are not writable
  assign sw_set = (wr && addr == `OFF_FLAG_SET) ? (AVS_WRITEDATA[`FLAG_W-1:0] & `FLAG_SW_MASK) : '0;
  assign sw_clr = (wr && addr == `OFF_FLAG_CLR) ? (AVS_WRITEDATA[`FLAG_W-1:0] & `FLAG_SW_MASK) : '0;

  // Each flag: any set beats any clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < `FLAG_W; gi = gi + 1) begin : g_flag
      assign flags_d[gi] = hw_set[gi] || sw_set[gi] || (flags_q[gi] && !sw_clr[gi] && !hw_clr[gi]);
    end
  endgenerate

  // Flag register; room flag starts set
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      flags_q <= `FLAG_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Interrupt request from enabled flags only
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(flags_q & en_q);
    end
  end

  // Outputs, all from flip-flops
  assign AVS_READDATA    = rdata_q;
  assign AVS_WAITREQUEST = wait_q;
  assign RX_ENABLE       = rx_on_q;
  assign TX_ENABLE       = tx_on_q;
  assign TX_VALID        = v0_q;
  assign TX_FRAME        = d0_q;
  assign IRQ             = irq_q;

  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  property p_byte_pop;
    rd && addr == `OFF_RX_BYTE && rxb_v_q && !sh_v_q
      |=> !rxb_v_q && AVS_READDATA == {24'h00_0000, $past(rxb_q.data[7:0])};
  endproperty
  a_byte_pop: assert property (p_byte_pop) else $error("byte view read wrong");

  property p_ext_pop;
    rd && addr == `OFF_RX_EXT_POP && rxb_v_q && !sh_v_q
      |=> !rxb_v_q && AVS_READDATA[`BIT_FRAMING_ERROR] == $past(rxb_q.framing_error) && AVS_READDATA[8:0] == $past(rxb_q.data);
  endproperty
  a_ext_pop: assert property (p_ext_pop) else $error("extended view read wrong");

  property p_peek;
    rd && addr == `OFF_RX_PEEK && rxb_v_q
      |=> rxb_v_q && AVS_READDATA[13:9] == 5'h00 && AVS_READDATA[`BIT_PARITY_ERROR] == $past(rxb_q.parity_error);
  endproperty
  a_peek: assert property (p_peek) else $error("peek removed frame");

  property p_rx_on_after;
    TX_SENT && busy_q && fl_q.rx_on |=> RX_ENABLE;
  endproperty
  a_rx_on_after: assert property (p_rx_on_after) else $error("receiver not enabled after frame");

  property p_tx_off_after;
    TX_SENT && busy_q && fl_q.tx_off && !(wr && addr == `OFF_CMD) |=> !TX_ENABLE;
  endproperty
  a_tx_off_after: assert property (p_tx_off_after) else $error("transmitter not disabled after frame");

  property p_byte_write;
    wr && addr == `OFF_TX_BYTE && !v0_q |=> TX_VALID && TX_FRAME.data[8] == 1'b0 && !TX_FRAME.brk && !TX_FRAME.rx_on;
  endproperty
  a_byte_write: assert property (p_byte_write) else $error("byte write kept high bits");

  property p_tx_ovf;
    tx_wr && v1_q && !TX_READY |=> flags_q[`FL_TX_OVF] && $stable(d1_q) && $stable(d0_q);
  endproperty
  a_tx_ovf: assert property (p_tx_ovf) else $error("overflow write not discarded");

  property p_rx_unf;
    rd_pop && !rxb_v_q |=> flags_q[`FL_RX_UNF] && !AVS_WAITREQUEST;
  endproperty
  a_rx_unf: assert property (p_rx_unf) else $error("underflow flag missing");

  property p_rx_ovf;
    rx_acc && sh_v_q && !move |=> flags_q[`FL_RX_OVF] && sh_q == $past(RX_FRAME);
  endproperty
  a_rx_ovf: assert property (p_rx_ovf) else $error("receive overflow not handled");

  property p_irq;
    (flags_q & en_q) != 11'h000 |=> IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled flag gave no interrupt");

  property p_irq_quiet;
    (flags_q & en_q) == 11'h000 |=> !IRQ;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without enabled flag");

endmodule

// [testbench/le_uart_peer.sv]
// Far-side model: receive engine handing frames over, transmit engine taking them.
// Assumes go() is called just after a rising edge; STALL holds the transmit side.
module le_uart_peer
  import le_uart_buf_pkg::*;
(
  // Clock
  input  wire logic       CLOCK,
  // Receive engine outputs
  output logic            RX_FRAME_VALID,
  output rx_frame_t       RX_FRAME,
  output rx_detect_t      RX_DETECT,
  // Transmit engine
  input  wire logic       TX_VALID,
  input  wire tx_frame_t  TX_FRAME,
  input  wire logic       TX_ENABLE,
  output logic            TX_READY,
  output logic            TX_SENT,
  // Bench control
  input  wire logic       STALL
);
  timeunit 1ns;
  timeprecision 1ns;
  tx_frame_t  got[$];
  rx_frame_t  p_f;
  rx_detect_t p_d;
  logic       p_v;
  int         req;
  int         ack;
  int         cnt;

  initial begin
    RX_FRAME_VALID = 1'b0;
    RX_FRAME = 11'h5A5;
    RX_DETECT = 3'h0;
    TX_READY = 1'b0;
    TX_SENT = 1'b0;
    req = 0;
    ack = 0;
    cnt = 0;
  end

  // Queue one receive event for the next edge
  task automatic go(input logic v, input rx_frame_t f, input rx_detect_t d);
    p_v <= v;
    p_f <= f;
    p_d <= d;
    req <= req + 1;
  endtask

  // Idle frame lines toggle, so a stale word never looks like data
  always @(posedge CLOCK) begin
    if (req != ack) begin
      RX_FRAME_VALID <= p_v;
      RX_FRAME <= p_v ? p_f : ~RX_FRAME;
      RX_DETECT <= p_d;
      ack <= req;
    end else begin
      RX_FRAME_VALID <= 1'b0;
      RX_DETECT <= 3'h0;
      RX_FRAME <= ~RX_FRAME;
    end
  end

  // One frame in flight; sending takes a random, sometimes long, time
  always @(posedge CLOCK) begin
    TX_SENT <= 1'b0;
    if (TX_READY && TX_VALID) begin
      TX_READY <= 1'b0;
      got.push_back(TX_FRAME);
      cnt <= 2 + int'($urandom % 12);
    end else if (cnt == 1) begin
      TX_SENT <= 1'b1;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else begin
      TX_READY <= !STALL && TX_ENABLE && TX_VALID;
    end
  end
endmodule

// [testbench/low_energy_uart_buffers_and_flags_tb_top.sv]
// Self-checking bench for the serial buffer and flag block.
// Assumes the far-side model le_uart_peer and a 50 ns clock.
`include "le_uart_buf_defs.svh"
module low_energy_uart_buffers_and_flags_tb_top
  import le_uart_buf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CLOCK, SYS_RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, RX_FRAME_VALID, RX_ENABLE;
  logic        TX_VALID, TX_READY, TX_SENT, TX_ENABLE, IRQ, stall;
  logic [7:0]  AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, q, w1, w2, w3;
  rx_frame_t   RX_FRAME, f, f1, f3;
  rx_detect_t  RX_DETECT;
  tx_frame_t   TX_FRAME;
  int          num_errors, checks;

  le_uart_buf le_uart_buf_i (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .RX_FRAME_VALID(RX_FRAME_VALID), .RX_FRAME(RX_FRAME),
    .RX_DETECT(RX_DETECT), .RX_ENABLE(RX_ENABLE), .TX_VALID(TX_VALID), .TX_FRAME(TX_FRAME),
    .TX_READY(TX_READY), .TX_SENT(TX_SENT), .TX_ENABLE(TX_ENABLE), .IRQ(IRQ));
  le_uart_peer le_uart_peer_i (.CLOCK(CLOCK), .RX_FRAME_VALID(RX_FRAME_VALID), .RX_FRAME(RX_FRAME),
    .RX_DETECT(RX_DETECT), .TX_VALID(TX_VALID), .TX_FRAME(TX_FRAME), .TX_ENABLE(TX_ENABLE),
    .TX_READY(TX_READY), .TX_SENT(TX_SENT), .STALL(stall));

  // Clock, 50 ns period
  always #25 CLOCK = ~CLOCK;

  // Bus cycle held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    @(posedge CLOCK);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLOCK);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Expected views and flags, worked out from the frame
  function automatic logic [31:0] ext_view(input rx_frame_t x);
    return {16'h0000, x.framing_error, x.parity_error, 5'h00, x.data};
  endfunction
  function automatic logic [31:0] flg(input rx_frame_t x, input logic v);
    return {21'h00_0000, 3'h0, x.framing_error, x.parity_error, 3'h0, v, 2'h2};
  endfunction
  function automatic tx_frame_t tx_exp(input logic ext, input logic [31:0] d);
    return ext ? {d[15:13], d[8:0]} : {4'h0, d[7:0]};
  endfunction

  // Watchdog, far beyond the expected run length
  initial begin
    #(50 * 40000);
    num_errors++;
    test_done;
  end

  initial begin
    void'($urandom(40933));
    {CLOCK, AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA} = '0;
    SYS_RST = 1'b1;
    stall = 1'b1;
    cyc(12);
    SYS_RST <= 1'b0;
    cyc(1);
    rd(`OFF_FLAGS);
    chk("flags_reset", 32'h0000_0002, q);
    rd(`OFF_RX_BYTE);
    rd(`OFF_FLAGS);
    chk("underflow", 32'h0000_0012, q);
    wr(`OFF_CMD, 32'h0000_0001);
    $display("reset and underflow done");
    // Random frames through peek, extended and byte views
    for (int i = 0; i < 4; i++) begin
      f = rx_frame_t'(11'($urandom));
      wr(`OFF_FLAG_CLR, 32'hFFFF_FFFF);
      le_uart_peer_i.go(1'b1, f, 3'h0);
      cyc(4);
      rd(`OFF_FLAGS);
      chk("flags_rx", flg(f, 1'b1), q);
      rd(`OFF_RX_PEEK);
      chk("peek", ext_view(f), q);
      rd(`OFF_RX_PEEK);
      chk("peek_again", ext_view(f), q);
      rd(i[0] ? `OFF_RX_BYTE : `OFF_RX_EXT_POP);
      chk("pop", i[0] ? {24'h00_0000, f.data[7:0]} : ext_view(f), q);
      rd(`OFF_FLAGS);
      chk("flags_pop", flg(f, 1'b0), q);
    end
    // Blocking drops the frame and its error marks
    wr(`OFF_FLAG_CLR, 32'hFFFF_FFFF);
    wr(`OFF_CMD, 32'h0000_0010);
    le_uart_peer_i.go(1'b1, 11'h7FF, 3'h0);
    cyc(4);
    rd(`OFF_FLAGS);
    chk("blocked", 32'h0000_0002, q);
    wr(`OFF_CMD, 32'h0000_0020);
    // Three frames against one buffer entry and the shifter
    f1 = rx_frame_t'({2'h0, 9'($urandom)});
    f3 = rx_frame_t'({2'h0, 9'($urandom)});
    le_uart_peer_i.go(1'b1, f1, 3'h0);
    cyc(4);
    le_uart_peer_i.go(1'b1, ~f3, 3'h0);
    cyc(4);
    le_uart_peer_i.go(1'b1, f3, 3'h0);
    cyc(4);
    rd(`OFF_FLAGS);
    chk("rx_ovf", 32'h0000_0001, {31'h0, q[3]});
    rd(`OFF_RX_EXT_POP);
    chk("ovf_first", ext_view(f1), q);
    rd(`OFF_RX_EXT_POP);
    chk("ovf_kept", ext_view(f3), q);
    $display("receive done");
    // Each kind of detected frame
    for (int k = 0; k < 3; k++) begin
      wr(`OFF_FLAG_CLR, 32'hFFFF_FFFF);
      le_uart_peer_i.go(1'b0, 11'h000, 3'(1 << k));
      cyc(4);
      rd(`OFF_FLAGS);
      chk("detect", 32'h0000_0002 | (32'h0000_0100 << k), q);
    end
    // Set, clear, enables, reserved and unmapped places
    wr(`OFF_ENABLES, 32'hFFFF_FFFF);
    rd(`OFF_ENABLES);
    chk("enables", 32'h0000_07FF, q);
    wr(`OFF_ENABLES, 32'h0000_0400);
    wr(`OFF_FLAG_CLR, 32'hFFFF_FFFF);
    cyc(2);
    chk("irq_off", 32'h0, {31'h0, IRQ});
    wr(`OFF_FLAG_SET, 32'hFFFF_FFFF);
    rd(`OFF_FLAGS);
    chk("flag_set", 32'h0000_07FB, q);
    chk("irq_on", 32'h1, {31'h0, IRQ});
    wr(`OFF_FLAG_CLR, 32'h0000_0400);
    rd(`OFF_FLAGS);
    chk("flag_clr", 32'h0000_03FB, q);
    chk("irq_masked", 32'h0, {31'h0, IRQ});
    wr(`OFF_FLAG_CLR, 32'hFFFF_FFFF);
    rd(`OFF_FLAGS);
    chk("flag_clr_all", 32'h0000_0002, q);
    rd(8'h3C);
    chk("unmapped", 32'h0000_0000, q);
    $display("flags done");
    // Transmit: fill while the engine stalls, overflow, then drain
    wr(`OFF_CMD, 32'h0000_0004);
    w1 = $urandom;
    w2 = $urandom;
    w3 = $urandom;
    wr(`OFF_TX_BYTE, w1);
    wr(`OFF_TX_BYTE, w2);
    wr(`OFF_TX_BYTE, w3);
    rd(`OFF_FLAGS);
    chk("tx_full", 32'h0000_0020, q);
    stall <= 1'b0;
    q = '0;
    while (q[0] !== 1'b1) rd(`OFF_FLAGS);
    chk("tx_drained", 32'h0000_0023, q);
    chk("tx_count", 32'd2, le_uart_peer_i.got.size());
    chk("tx_first", 32'(tx_exp(1'b0, w1)), 32'(le_uart_peer_i.got[0]));
    chk("tx_second", 32'(tx_exp(1'b0, w2)), 32'(le_uart_peer_i.got[1]));
    // Extended frame with all three per-frame controls
    wr(`OFF_CMD, 32'h0000_0002);
    chk("rx_off", 32'h0, {31'h0, RX_ENABLE});
    w1 = ($urandom & 32'h0000_01FF) | 32'h0000_E000;
    wr(`OFF_TX_EXT, w1);
    while (TX_ENABLE !== 1'b0) @(posedge CLOCK);
    @(posedge CLOCK);
    chk("tx_ext", 32'(tx_exp(1'b1, w1)), 32'(le_uart_peer_i.got[2]));
    chk("rx_on_after", 32'h1, {31'h0, RX_ENABLE});
    chk("tx_off_after", 32'h0, {31'h0, TX_ENABLE});
    rd(`OFF_STATUS);
    chk("status", 32'h0000_0019, q);
    $display("transmit done");
    test_done;
  end
endmodule
